// ===== design/dspace_pkg.sv
// Constants and types shared by the data-space access logic
// How it works
// R1 - Five read-only 24-bit words form identifier
// R2 - Identifier words at 0x801200 through 0x801208
// R3 - Identifier has no write or erase path
// R4 - Effective address is 16-bit byte address
// R5 - Address bit 15 set goes to window
// R6 - Unimplemented lower-half reads return zero
// R7 - Low byte even address, high byte odd
// R8 - Post-increment adds one byte, two word
// R9 - Byte read selects lane onto low byte
// R10 - Shared word decode, separate byte strobes
// R11 - Odd word access raises address error
// R12 - Misaligned read completes, misaligned write suppressed
// R13 - Byte load keeps working register high byte
// R14 - Sign extend and zero extend operations
// R15 - 0x0000-0x0FFF special registers, unused read zero
// R16 - 13-bit direct field reaches 0x0000-0x1FFF
// R17 - 16-bit direct or indirect reaches everything
// R18 - Separate X and Y concurrent read paths
// R19 - X read bus serves unified reads
// R20 - Bit-reversed mode only for X writes
// R21 - Writes unified, X/Y boundary fixed
// R22 - Separate read and write address units
// R23 - Configuration reads need table page bit 7
// R24 - One-cycle address error with access type
package dspace_pkg;
  localparam int          EA_W        = 16;
  localparam int          NEAR_W      = 13;
  localparam int          RAM_WORDS   = 8192;
  localparam int          IDX_W       = 13;
  localparam logic [15:0] SFR_END     = 16'h0fff;
  localparam logic [15:0] RAM_BASE    = 16'h1000;
  localparam logic [15:0] RAM_END     = 16'h4fff;
  localparam logic [15:0] Y_BASE      = 16'h3000;
  localparam int          WIN_BIT     = 15;
  localparam int          UID_W       = 24;
  localparam int          UID_WORDS   = 5;
  localparam logic [23:0] UID_ADDR_1  = 24'h801200;
  localparam logic [23:0] UID_ADDR_2  = 24'h801202;
  localparam logic [23:0] UID_ADDR_3  = 24'h801204;
  localparam logic [23:0] UID_ADDR_4  = 24'h801206;
  localparam logic [23:0] UID_ADDR_5  = 24'h801208;
  localparam int          CFG_PAGE_BIT = 7;
  localparam int          ERR_RD_BIT  = 0;
  localparam int          ERR_WR_BIT  = 1;

  typedef enum logic [1:0] {REG_SFR, REG_RAM, REG_NONE, REG_WIN} region_type;
  typedef enum logic [1:0] {EXT_BYTE_LOAD, EXT_SIGN, EXT_ZERO, EXT_WORD} ext_op_type;

  function automatic region_type region_of(input logic [15:0] ea);
    if (ea[WIN_BIT])
      return REG_WIN;
    else if (ea <= SFR_END)
      return REG_SFR;
    else if (ea >= RAM_BASE && ea <= RAM_END)
      return REG_RAM;
    else
      return REG_NONE;
  endfunction
endpackage

// ===== design/data_space_access_unit.sv
// Data-space decode, lanes, address errors, X/Y reads and identifier
`timescale 1ns/1ns
`default_nettype none
module data_space_access_unit
  import dspace_pkg::*;
#(
  // Identifier contents, arbitrary values
  parameter logic [23:0] UID_WORD_1 = 24'h000001,
  parameter logic [23:0] UID_WORD_2 = 24'h000002,
  parameter logic [23:0] UID_WORD_3 = 24'h000003,
  parameter logic [23:0] UID_WORD_4 = 24'h000004,
  parameter logic [23:0] UID_WORD_5 = 24'h000005
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        xrd_req,
  input  wire logic [15:0] xrd_ea,
  input  wire logic        xrd_word,
  input  wire logic        xrd_near,
  output var  logic        xrd_valid_q,
  output var  logic [15:0] xrd_data_q,
  input  wire logic        yrd_req,
  input  wire logic [15:0] yrd_ea,
  output var  logic        yrd_valid_q,
  output var  logic [15:0] yrd_data_q,
  input  wire logic        wr_req,
  input  wire logic [15:0] wr_ea,
  input  wire logic        wr_word,
  input  wire logic        wr_near,
  input  wire logic        wr_bitrev,
  input  wire logic [15:0] wr_data,
  output var  logic        sfr_rd_q,
  output var  logic [11:0] sfr_raddr_q,
  input  wire logic [15:0] sfr_rdata,
  input  wire logic        sfr_hit,
  output var  logic        sfr_wr_q,
  output var  logic [11:0] sfr_waddr_q,
  output var  logic [1:0]  sfr_wbe_q,
  output var  logic [15:0] sfr_wdata_q,
  output var  logic        win_rd_q,
  output var  logic [14:0] win_addr_q,
  input  wire logic [15:0] win_rdata,
  output var  logic        addr_err_q,
  output var  logic [1:0]  err_type_q,
  input  wire logic        ptr_req,
  input  wire logic [15:0] ptr_src,
  input  wire logic        ptr_word,
  output var  logic [15:0] ptr_next_q,
  input  wire logic        ext_req,
  input  wire ext_op_type  ext_op,
  input  wire logic [15:0] ext_old,
  input  wire logic [15:0] ext_new,
  output var  logic [15:0] ext_result_q,
  input  wire logic        tbl_req,
  input  wire logic [7:0]  tbl_page,
  input  wire logic [15:0] tbl_addr,
  output var  logic        tbl_valid_q,
  output var  logic [23:0] tbl_data_q
);
  // Two byte-wide halves, one word decode
  logic [7:0] ram_lo [RAM_WORDS]; // [R10]
  logic [7:0] ram_hi [RAM_WORDS];

  logic [15:0] x_ea;
  logic [15:0] w_ea;
  region_type  x_reg;
  region_type  w_reg;
  logic        x_misal;
  logic        y_misal;
  logic        w_misal;
  logic        w_ok;
  logic [IDX_W-1:0] w_idx;

  // Near direct field is zero-extended, else full 16 bits
  assign x_ea = xrd_near ? {3'h0, xrd_ea[NEAR_W-1:0]} : xrd_ea; // [R16] [R17] [R4]
  assign w_ea = wr_near ? {3'h0, wr_ea[NEAR_W-1:0]} : wr_ea; // [R16] [R17]
  assign x_reg = region_of(x_ea); // [R5] [R15]
  assign w_reg = region_of(w_ea);
  assign x_misal = xrd_req && xrd_word && x_ea[0]; // [R11]
  assign y_misal = yrd_req && yrd_ea[0]; // [R11]
  assign w_misal = wr_req && wr_word && w_ea[0]; // [R11]
  // Bit-reversed pointers only ever target X RAM
  assign w_ok = wr_req && !w_misal && !(wr_bitrev && (w_reg != REG_RAM || w_ea >= Y_BASE)); // [R12] [R20]
  assign w_idx = IDX_W'((w_ea - RAM_BASE) >> 1);

  // Write path: unified X/Y range, own address unit
  always_ff @(posedge sys_clk) begin
    if (w_ok && w_reg == REG_RAM) begin // [R21] [R22]
      if (wr_word || !w_ea[0])
        ram_lo[w_idx] <= wr_data[7:0]; // [R7] [R10]
      if (wr_word || w_ea[0])
        ram_hi[w_idx] <= wr_word ? wr_data[15:8] : wr_data[7:0]; // [R7] [R10]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sfr_wr_q    <= 1'b0;
      sfr_waddr_q <= 12'h000;
      sfr_wbe_q   <= 2'h0;
      sfr_wdata_q <= 16'h0000;
    end else begin
      sfr_wr_q <= w_ok && w_reg == REG_SFR; // [R12]
      if (w_ok && w_reg == REG_SFR) begin
        sfr_waddr_q <= {w_ea[11:1], 1'b0};
        sfr_wbe_q   <= wr_word ? 2'h3 : (w_ea[0] ? 2'h2 : 2'h1); // [R10]
        sfr_wdata_q <= wr_word ? wr_data : {wr_data[7:0], wr_data[7:0]};
      end
    end
  end

  // X read stage one: decode and issue
  region_type       xs_reg_q;
  logic             xs_valid_q;
  logic             xs_byte_q;
  logic             xs_odd_q;
  logic [IDX_W-1:0] xs_idx_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xs_valid_q  <= 1'b0;
      xs_reg_q    <= REG_NONE;
      xs_byte_q   <= 1'b0;
      xs_odd_q    <= 1'b0;
      xs_idx_q    <= '0;
      sfr_rd_q    <= 1'b0;
      sfr_raddr_q <= 12'h000;
      win_rd_q    <= 1'b0;
      win_addr_q  <= 15'h0000;
    end else begin
      // Misaligned read still completes on the containing word
      xs_valid_q <= xrd_req; // [R12]
      sfr_rd_q   <= xrd_req && x_reg == REG_SFR;
      win_rd_q   <= xrd_req && x_reg == REG_WIN; // [R5]
      if (xrd_req) begin
        xs_reg_q    <= x_reg;
        xs_byte_q   <= !xrd_word;
        xs_odd_q    <= x_ea[0];
        xs_idx_q    <= IDX_W'((x_ea - RAM_BASE) >> 1);
        sfr_raddr_q <= {x_ea[11:1], 1'b0};
        win_addr_q  <= {x_ea[14:1], 1'b0};
      end
    end
  end

  // X read stage two: select source and byte lane
  logic [15:0] x_word;
  always_comb begin
    case (xs_reg_q)
      REG_RAM: x_word = {ram_hi[xs_idx_q], ram_lo[xs_idx_q]};
      REG_SFR: x_word = sfr_hit ? sfr_rdata : 16'h0000; // [R15]
      REG_WIN: x_word = win_rdata;
      default: x_word = 16'h0000; // [R6]
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      xrd_valid_q <= 1'b0;
      xrd_data_q  <= 16'h0000;
    end else begin
      xrd_valid_q <= xs_valid_q; // [R19]
      if (xs_valid_q)
        xrd_data_q <= xs_byte_q ? {8'h00, xs_odd_q ? x_word[15:8] : x_word[7:0]} : x_word; // [R9]
    end
  end

  // Y path: word reads of Y RAM only, same latency as X
  logic             ys_valid_q;
  logic             ys_in_q;
  logic [IDX_W-1:0] ys_idx_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ys_valid_q  <= 1'b0;
      ys_in_q     <= 1'b0;
      ys_idx_q    <= '0;
      yrd_valid_q <= 1'b0;
      yrd_data_q  <= 16'h0000;
    end else begin
      ys_valid_q  <= yrd_req; // [R18]
      yrd_valid_q <= ys_valid_q;
      if (yrd_req) begin
        ys_in_q  <= yrd_ea >= Y_BASE && yrd_ea <= RAM_END; // [R21]
        ys_idx_q <= IDX_W'((yrd_ea - RAM_BASE) >> 1);
      end
      if (ys_valid_q)
        yrd_data_q <= ys_in_q ? {ram_hi[ys_idx_q], ram_lo[ys_idx_q]} : 16'h0000; // [R18]
    end
  end

  // Address error pulse, one per offending cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      addr_err_q <= 1'b0;
      err_type_q <= 2'h0;
    end else begin
      addr_err_q <= x_misal || y_misal || w_misal; // [R24] [R11]
      err_type_q[ERR_RD_BIT] <= x_misal || y_misal; // [R24]
      err_type_q[ERR_WR_BIT] <= w_misal; // [R24]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      ptr_next_q <= 16'h0000;
    else if (ptr_req)
      ptr_next_q <= ptr_src + (ptr_word ? 16'h0002 : 16'h0001); // [R8]
  end

  always_ff @(posedge sys_clk) begin
    if (rst)
      ext_result_q <= 16'h0000;
    else if (ext_req) begin
      case (ext_op)
        EXT_BYTE_LOAD: ext_result_q <= {ext_old[15:8], ext_new[7:0]}; // [R13]
        EXT_SIGN:      ext_result_q <= {{8{ext_old[7]}}, ext_old[7:0]}; // [R14]
        EXT_ZERO:      ext_result_q <= {8'h00, ext_old[7:0]}; // [R14]
        default:       ext_result_q <= ext_new;
      endcase
    end
  end

  // Identifier is constant logic: nothing here can write it
  logic [23:0] tbl_full;
  logic [23:0] uid_sel;
  assign tbl_full = {tbl_page, tbl_addr};
  always_comb begin
    uid_sel = 24'h000000;
    if (tbl_page[CFG_PAGE_BIT]) begin // [R23]
      case (tbl_full)
        UID_ADDR_1: uid_sel = UID_WORD_1; // [R1] [R2]
        UID_ADDR_2: uid_sel = UID_WORD_2;
        UID_ADDR_3: uid_sel = UID_WORD_3;
        UID_ADDR_4: uid_sel = UID_WORD_4;
        UID_ADDR_5: uid_sel = UID_WORD_5;
        default:    uid_sel = 24'h000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tbl_valid_q <= 1'b0;
      tbl_data_q  <= 24'h000000;
    end else begin
      tbl_valid_q <= tbl_req;
      if (tbl_req)
        tbl_data_q <= uid_sel; // [R3]
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_err_write;
    wr_req && wr_word && w_ea[0] |=> addr_err_q && err_type_q[ERR_WR_BIT];
  endproperty
  a_err_write: assert property (p_err_write) else $error("no write address error"); // [R11]

  property p_wr_suppress;
    wr_req && wr_word && w_ea[0] |=> !sfr_wr_q;
  endproperty
  a_wr_suppress: assert property (p_wr_suppress) else $error("misaligned write done"); // [R12]

  property p_unimpl_zero;
    xrd_req && region_of(x_ea) == REG_NONE |-> ##2 xrd_valid_q && xrd_data_q == 16'h0000;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented not zero"); // [R6]

  property p_byte_lane;
    xrd_req && !xrd_word |-> ##2 xrd_data_q[15:8] == 8'h00;
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte read high lane set"); // [R9]

  property p_ptr_byte;
    ptr_req && !ptr_word |=> ptr_next_q == $past(ptr_src) + 16'h0001;
  endproperty
  a_ptr_byte: assert property (p_ptr_byte) else $error("byte post-increment wrong"); // [R8]

  property p_byte_load;
    ext_req && ext_op == EXT_BYTE_LOAD |=> ext_result_q[15:8] == $past(ext_old[15:8]);
  endproperty
  a_byte_load: assert property (p_byte_load) else $error("byte load hit high byte"); // [R13]

  property p_sign;
    ext_req && ext_op == EXT_SIGN |=> ext_result_q[15:8] == {8{ext_result_q[7]}};
  endproperty
  a_sign: assert property (p_sign) else $error("sign extend wrong"); // [R14]

  property p_win;
    xrd_req && x_ea[WIN_BIT] |=> win_rd_q && !sfr_rd_q;
  endproperty
  a_win: assert property (p_win) else $error("window read not issued"); // [R5]

  property p_uid_gate;
    tbl_req && !tbl_page[CFG_PAGE_BIT] |=> tbl_valid_q && tbl_data_q == 24'h000000;
  endproperty
  a_uid_gate: assert property (p_uid_gate) else $error("config read without page bit"); // [R23]

  property p_sfr_be;
    wr_req && !wr_word && !w_ea[0] && !wr_bitrev && region_of(w_ea) == REG_SFR
      |=> sfr_wr_q && sfr_wbe_q == 2'h1;
  endproperty
  a_sfr_be: assert property (p_sfr_be) else $error("even byte strobe wrong"); // [R10]

  property p_err_read;
    xrd_req && xrd_word && x_ea[0] |=> addr_err_q && err_type_q[ERR_RD_BIT];
  endproperty
  a_err_read: assert property (p_err_read) else $error("no read address error"); // [R11]

  property p_err_y;
    yrd_req && yrd_ea[0] |=> addr_err_q && err_type_q[ERR_RD_BIT];
  endproperty
  a_err_y: assert property (p_err_y) else $error("no Y address error"); // [R11]

  property p_err_idle;
    !xrd_req && !yrd_req && !wr_req |=> !addr_err_q;
  endproperty
  a_err_idle: assert property (p_err_idle) else $error("address error without access"); // [R24]

  property p_byte_no_err;
    xrd_req && !xrd_word && !yrd_req && !wr_req |=> !addr_err_q;
  endproperty
  a_byte_no_err: assert property (p_byte_no_err) else $error("byte read trapped"); // [R11]

  property p_x_latency;
    xrd_req |-> ##2 xrd_valid_q;
  endproperty
  a_x_latency: assert property (p_x_latency) else $error("X read answer late"); // [R19]

  property p_y_latency;
    yrd_req |-> ##2 yrd_valid_q;
  endproperty
  a_y_latency: assert property (p_y_latency) else $error("Y read answer late"); // [R18]

  property p_y_outside;
    yrd_req && yrd_ea < Y_BASE |-> ##2 yrd_data_q == 16'h0000;
  endproperty
  a_y_outside: assert property (p_y_outside) else $error("Y read outside Y not zero"); // [R21]

  property p_ptr_word;
    ptr_req && ptr_word |=> ptr_next_q == $past(ptr_src) + 16'h0002;
  endproperty
  a_ptr_word: assert property (p_ptr_word) else $error("word post-increment wrong"); // [R8]

  property p_zero;
    ext_req && ext_op == EXT_ZERO |=> ext_result_q[15:8] == 8'h00;
  endproperty
  a_zero: assert property (p_zero) else $error("zero extend left high byte"); // [R14]

  property p_sfr_be_odd;
    wr_req && !wr_word && w_ea[0] && !wr_bitrev && region_of(w_ea) == REG_SFR
      |=> sfr_wr_q && sfr_wbe_q == 2'h2;
  endproperty
  a_sfr_be_odd: assert property (p_sfr_be_odd) else $error("odd byte strobe wrong"); // [R10]

  property p_bitrev_sfr;
    wr_req && wr_bitrev && region_of(w_ea) == REG_SFR |=> !sfr_wr_q;
  endproperty
  a_bitrev_sfr: assert property (p_bitrev_sfr) else $error("bit-reversed write left X"); // [R20]

  property p_sfr_rd;
    xrd_req && region_of(x_ea) == REG_SFR |=> sfr_rd_q && !win_rd_q;
  endproperty
  a_sfr_rd: assert property (p_sfr_rd) else $error("register read not issued"); // [R15]

  property p_near_low;
    xrd_req && xrd_near |=> !win_rd_q;
  endproperty
  a_near_low: assert property (p_near_low) else $error("near read reached window"); // [R16]

  property p_uid_first;
    tbl_req && tbl_full == UID_ADDR_1 |=> tbl_valid_q && tbl_data_q == UID_WORD_1;
  endproperty
  a_uid_first: assert property (p_uid_first) else $error("identifier word 1 misplaced"); // [R2]
endmodule
`default_nettype wire

// ===== verification/periph_model.sv
// Peripheral register and program window responder
`timescale 1ns/1ns
`default_nettype none
module periph_model (
  input  wire logic        sys_clk,
  input  wire logic        sfr_rd_q,
  input  wire logic [11:0] sfr_raddr_q,
  input  wire logic        sfr_wr_q,
  input  wire logic [11:0] sfr_waddr_q,
  input  wire logic [1:0]  sfr_wbe_q,
  input  wire logic [15:0] sfr_wdata_q,
  input  wire logic        win_rd_q,
  input  wire logic [14:0] win_addr_q,
  output logic      [15:0] sfr_rdata,
  output logic             sfr_hit,
  output logic      [15:0] win_rdata
);
  logic [15:0] regs [0:63];
  // Idle buses show inverted data so stale values never pass
  always_comb begin
    sfr_hit = sfr_raddr_q < 12'h080;
    sfr_rdata = regs[sfr_raddr_q[6:1]] ^ {16{!sfr_rd_q}};
    win_rdata = {1'b1, win_addr_q} ^ {16{!win_rd_q}} ^ 16'h5a5a;
  end
  always_ff @(posedge sys_clk) begin
    if (sfr_wr_q && sfr_waddr_q < 12'h080) begin
      if (sfr_wbe_q[0])
        regs[sfr_waddr_q[6:1]][7:0] <= sfr_wdata_q[7:0];
      if (sfr_wbe_q[1])
        regs[sfr_waddr_q[6:1]][15:8] <= sfr_wdata_q[15:8];
    end
  end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the data-space access unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import dspace_pkg::*;
  logic        sys_clk, rst, xrd_req, xrd_word, xrd_near, yrd_req, xrd_valid_q, yrd_valid_q;
  logic        wr_req, wr_word, wr_near, wr_bitrev, sfr_rd_q, sfr_hit, sfr_wr_q, win_rd_q;
  logic        addr_err_q, ptr_req, ptr_word, ext_req, tbl_req, tbl_valid_q;
  logic [15:0] xrd_ea, yrd_ea, wr_ea, wr_data, xrd_data_q, yrd_data_q, sfr_rdata, sfr_wdata_q;
  logic [15:0] win_rdata, ptr_src, ptr_next_q, ext_old, ext_new, ext_result_q, tbl_addr;
  logic [11:0] sfr_raddr_q, sfr_waddr_q;
  logic [1:0]  sfr_wbe_q, err_type_q;
  logic [14:0] win_addr_q;
  logic [7:0]  tbl_page;
  logic [23:0] tbl_data_q;
  ext_op_type  ext_op;
  logic [15:0] xd, yd;
  logic [2:0]  e;
  int          n_mismatch, check_count, cycles;
  // Arbitrary identifier contents
  logic [23:0] uid [0:5] = '{24'h1a2b3c, 24'h4d5e6f, 24'h708192, 24'ha3b4c5, 24'hd6e7f8, 24'h0};

  data_space_access_unit #(.UID_WORD_1(24'h1a2b3c), .UID_WORD_2(24'h4d5e6f),
    .UID_WORD_3(24'h708192), .UID_WORD_4(24'ha3b4c5), .UID_WORD_5(24'hd6e7f8)) uut (
    .sys_clk(sys_clk), .rst(rst), .xrd_req(xrd_req), .xrd_ea(xrd_ea), .xrd_word(xrd_word),
    .xrd_near(xrd_near), .xrd_valid_q(xrd_valid_q), .xrd_data_q(xrd_data_q),
    .yrd_req(yrd_req), .yrd_ea(yrd_ea), .yrd_valid_q(yrd_valid_q), .yrd_data_q(yrd_data_q),
    .wr_req(wr_req), .wr_ea(wr_ea), .wr_word(wr_word), .wr_near(wr_near),
    .wr_bitrev(wr_bitrev), .wr_data(wr_data), .sfr_rd_q(sfr_rd_q), .sfr_raddr_q(sfr_raddr_q),
    .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .sfr_wr_q(sfr_wr_q), .sfr_waddr_q(sfr_waddr_q),
    .sfr_wbe_q(sfr_wbe_q), .sfr_wdata_q(sfr_wdata_q), .win_rd_q(win_rd_q),
    .win_addr_q(win_addr_q), .win_rdata(win_rdata), .addr_err_q(addr_err_q),
    .err_type_q(err_type_q), .ptr_req(ptr_req), .ptr_src(ptr_src), .ptr_word(ptr_word),
    .ptr_next_q(ptr_next_q), .ext_req(ext_req), .ext_op(ext_op), .ext_old(ext_old),
    .ext_new(ext_new), .ext_result_q(ext_result_q), .tbl_req(tbl_req), .tbl_page(tbl_page),
    .tbl_addr(tbl_addr), .tbl_valid_q(tbl_valid_q), .tbl_data_q(tbl_data_q));
  periph_model peri (
    .sys_clk(sys_clk), .sfr_rd_q(sfr_rd_q), .sfr_raddr_q(sfr_raddr_q), .sfr_wr_q(sfr_wr_q),
    .sfr_waddr_q(sfr_waddr_q), .sfr_wbe_q(sfr_wbe_q), .sfr_wdata_q(sfr_wdata_q),
    .win_rd_q(win_rd_q), .win_addr_q(win_addr_q), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .win_rdata(win_rdata));

  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads: answer two cycles after the request, error flag after one
  task automatic rd(input logic [15:0] xa, input logic w, n, yr, input logic [15:0] ya);
    @(negedge sys_clk);
    {xrd_req, xrd_ea, xrd_word, xrd_near, yrd_req, yrd_ea} = {1'b1, xa, w, n, yr, ya};
    @(negedge sys_clk);
    {xrd_req, yrd_req} = 2'b00;
    e = {addr_err_q, err_type_q};
    @(negedge sys_clk);
    chk(xrd_valid_q, 1);
    chk(yrd_valid_q, yr);
    {xd, yd} = {xrd_data_q, yrd_data_q};
  endtask

  task automatic wr(input logic [15:0] a, input logic w, n, b, input logic [15:0] d);
    @(negedge sys_clk);
    {wr_req, wr_ea, wr_word, wr_near, wr_bitrev, wr_data} = {1'b1, a, w, n, b, d};
    @(negedge sys_clk);
    wr_req = 0;
    e = {addr_err_q, err_type_q};
  endtask

  task automatic ext(input ext_op_type op, input logic [15:0] o, nw, exp);
    @(negedge sys_clk);
    {ext_req, ext_old, ext_new} = {1'b1, o, nw};
    ext_op = op;
    @(negedge sys_clk);
    ext_req = 0;
    chk(ext_result_q, exp);
  endtask

  task automatic tbl(input logic [7:0] p, input logic [15:0] a, input logic [23:0] exp);
    @(negedge sys_clk);
    {tbl_req, tbl_page, tbl_addr} = {1'b1, p, a};
    @(negedge sys_clk);
    tbl_req = 0;
    chk(tbl_valid_q, 1);
    chk(tbl_data_q, exp);
  endtask

  task automatic t_lanes();
    wr(16'h1000, 1, 0, 0, 16'h1234);
    chk(e, 0);
    rd(16'h1000, 0, 0, 0, 0);
    chk(xd, 16'h0034);
    rd(16'h1001, 0, 0, 0, 0);
    chk(xd, 16'h0012);
    wr(16'h1001, 0, 0, 0, 16'h00ab);
    rd(16'h1000, 1, 0, 0, 0);
    chk(xd, 16'hab34);
  endtask

  task automatic t_misalign();
    wr(16'h1002, 1, 0, 0, 16'h0f0f);
    wr(16'h1003, 1, 0, 0, 16'hffff);
    chk(e, 3'b110);
    rd(16'h1003, 1, 0, 0, 0);
    chk(e, 3'b101);
    chk(xd, 16'h0f0f);
  endtask

  task automatic t_regions();
    wr(16'h5000, 1, 0, 0, 16'h7777);
    rd(16'h5000, 1, 0, 0, 0);
    chk(xd, 0);
    rd(16'h0f00, 1, 0, 0, 0);
    chk(xd, 0);
    rd(16'h8124, 1, 0, 0, 0);
    chk(xd, 16'hdb7e);
    wr(16'h0010, 1, 0, 0, 16'hbeef);
    chk({sfr_wr_q, sfr_waddr_q, sfr_wbe_q}, {1'b1, 12'h010, 2'b11});
    wr(16'h0011, 0, 0, 0, 16'h0077);
    chk({sfr_wbe_q, sfr_wdata_q}, {2'b10, 16'h7777});
    rd(16'h0010, 1, 0, 0, 0);
    chk(xd, 16'h77ef);
  endtask

  task automatic t_near_xy();
    wr(16'hf004, 1, 1, 0, 16'h4321);
    rd(16'h7004, 1, 1, 0, 0);
    chk(xd, 16'h4321);
    wr(16'h3000, 1, 0, 0, 16'h5566);
    wr(16'h3010, 1, 0, 0, 16'h0000);
    rd(16'h1000, 1, 0, 1, 16'h3000);
    chk({xd, yd}, {16'hab34, 16'h5566});
    rd(16'h3000, 1, 0, 1, 16'h2000);
    chk({xd, yd}, {16'h5566, 16'h0});
    rd(16'h1000, 1, 0, 1, 16'h3001);
    chk(e, 3'b101);
    wr(16'h1010, 1, 0, 1, 16'h1111);
    wr(16'h3010, 1, 0, 1, 16'h2222);
    chk(e, 0);
    rd(16'h1010, 1, 0, 1, 16'h3010);
    chk({xd, yd}, {16'h1111, 16'h0});
  endtask

  initial begin
    {rst, xrd_req, yrd_req, wr_req, ptr_req, ext_req, tbl_req} = 7'h40;
    {xrd_ea, xrd_word, xrd_near, yrd_ea, wr_ea, wr_word, wr_near, wr_bitrev} = '0;
    {wr_data, ptr_src, ptr_word, ext_old, ext_new, tbl_page, tbl_addr} = '0;
    ext_op = EXT_WORD;
    repeat (2) @(negedge sys_clk);
    rst = 0;
    chk({xrd_valid_q, yrd_valid_q, addr_err_q, tbl_valid_q, sfr_wr_q}, 0);
    t_lanes();
    t_misalign();
    t_regions();
    t_near_xy();
    for (int w = 0; w < 2; w++) begin
      @(negedge sys_clk);
      {ptr_req, ptr_src, ptr_word} = {1'b1, 16'h10ff, w[0]};
      @(negedge sys_clk);
      ptr_req = 0;
      chk(ptr_next_q, 16'h1100 + w);
    end
    ext(EXT_BYTE_LOAD, 16'habcd, 16'h0012, 16'hab12);
    ext(EXT_SIGN, 16'h1280, 16'h1280, 16'hff80);
    ext(EXT_ZERO, 16'habcd, 16'habcd, 16'h00cd);
    ext(EXT_WORD, 16'habcd, 16'h5678, 16'h5678);
    for (int i = 0; i < 6; i++)
      tbl(8'h80, 16'h1200 + 2 * i, uid[i]);
    tbl(8'h00, 16'h1200, 0);
    tbl(8'h80, 16'h1201, 0);
    report_and_stop();
  end
endmodule
`default_nettype wire
